/* uart_line_control_regs_bench.sv */
/*
 Self-checking bench for the line control block: register map, transmit
 framing, receive checking, transmit FIFO fill and break.
 Assumes ulc_pkg and the far-end terminal model are compiled first.
*/
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module uart_line_control_regs_bench;
  import ulc_pkg::*;
  localparam int DIV = 2;
  localparam int BIT = 16 * DIV;
  logic        mclk, rstn, cs, rd, wr, serial_tx_pin, tx_fifo_ready, dtr, rts;
  logic        serial_rx_pin;
  logic [2:0]  addr;
  logic [7:0]  wdata, rdata, v;
  logic [3:0]  modem_in;
  logic [11:0] b;
  int          n_fail, samples_checked, nb, tk, acc, bad, f0, dg;
  logic [7:0]  cfg [10] = '{8'h03, 8'h00, 8'h04, 8'h07, 8'h05,
                            8'h0B, 8'h1B, 8'h2B, 8'h3B, 8'h0A};
  logic [7:0]  dat [10] = '{8'hA6, 8'h13, 8'h15, 8'h81, 8'h2D,
                            8'hC4, 8'hC4, 8'h5A, 8'h5A, 8'h6B};

  ulc_top dut (.mclk(mclk), .rstn(rstn), .cs(cs), .addr(addr), .rd(rd), .wr(wr),
    .wdata(wdata), .rdata(rdata), .tx_fifo_ready(tx_fifo_ready),
    .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
    .modem_in(modem_in), .dtr(dtr), .rts(rts));
  ulc_far_end #(.BIT(BIT)) p (.mclk(mclk), .tx(serial_tx_pin), .rx(serial_rx_pin));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic results;
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // acc counts writes made while the buffer showed room
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    acc += int'(tx_fifo_ready);
    {cs, wr, addr, wdata} = {2'b11, a, d};
    @(negedge mclk);
    {cs, wr} = 2'b00;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(negedge mclk);
    {cs, rd, addr} = {2'b11, a};
    @(negedge mclk);
    {cs, rd} = 2'b00;
    d = rdata;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] m, e);
    rreg(a, v);
    `CHK(v & m, e)
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      rreg(OFS_LSR, v);
      k++;
    end while (v[6] !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      n_fail++;
      results();
    end
    repeat (BIT) @(negedge mclk);
  endtask

  // expected line bits from start to first stop, and ticks start to start
  function automatic void frame(input logic [7:0] l, d, output logic [11:0] fb,
                                output int fn, ft);
    int n;
    n = 5 + int'(l[1:0]);
    fb = '0;
    for (int i = 0; i < n; i++) fb[i+1] = d[i];
    fn = n + 1;
    if (l[LCR_PEN]) begin
      fb[fn] = l[LCR_STP] ? !l[LCR_EPS] : (^fb) ^ !l[LCR_EPS];
      fn++;
    end
    fb[fn] = 1'b1;
    fn++;
    ft = 16 * (fn - 1) + (!l[LCR_STB] ? 16 : (n == 5 ? 24 : 32));
  endfunction

  task automatic rx_case(input logic [7:0] l, d, input logic [11:0] flip,
                         input logic [7:0] lsr_e, rbr_e);
    frame(l, d, b, nb, tk);
    wreg(OFS_LCR, l);
    p.send(b ^ flip, nb);
    repeat (BIT) @(negedge mclk);
    rchk(OFS_LSR, 8'h0F, lsr_e);
    rchk(OFS_DATA, 8'hFF, rbr_e);
    // a low stop bit can look like a fresh start; let that char pass and drain it
    repeat (12 * BIT) @(negedge mclk);
    rreg(OFS_LSR, v);
    rreg(OFS_DATA, v);
  endtask

  initial begin
    {cs, rd, wr, addr, wdata} = '0;
    modem_in = 4'hA;
    n_fail = 0;
    samples_checked = 0;
    acc = 0;
    bad = 0;
    rstn = 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    rchk(OFS_LCR, 8'hFF, RST_LCR);
    rchk(OFS_SCR, 8'hFF, RST_SCR);
    rchk(OFS_IIR, 8'hFF, RST_IIR);
    rchk(OFS_LSR, 8'hFF, 8'h60);
    rchk(OFS_MSR, 8'hF0, 8'hA0);
    wreg(OFS_LCR, 8'h80);
    wreg(OFS_IER, 8'hA5);
    rchk(OFS_IER, 8'hFF, 8'hA5);
    wreg(OFS_IER, 8'h00);
    wreg(OFS_DATA, 8'(DIV));
    rchk(OFS_DATA, 8'hFF, 8'(DIV));
    rchk(OFS_LCR, 8'hFF, 8'h80);
    wreg(OFS_SCR, 8'h3C);
    wreg(OFS_MCR, 8'h03);
    wreg(OFS_LSR, 8'h00);
    wreg(OFS_IIR, 8'hFF);
    wreg(OFS_LCR, 8'h03);
    wreg(OFS_IER, 8'hFF);
    rchk(OFS_IER, 8'hFF, 8'h0F);
    rchk(OFS_DATA, 8'hFF, 8'h00);
    rchk(OFS_SCR, 8'hFF, 8'h3C);
    rchk(OFS_MCR, 8'hFF, 8'h03);
    `CHK({dtr, rts}, 2'b11)
    rchk(OFS_LSR, 8'hFF, 8'h60);
    rchk(OFS_IIR, 8'hFF, 8'h01);
    // two characters per format: the second start edge times the first
    for (int c = 0; c < 10; c++) begin
      wreg(OFS_LCR, cfg[c]);
      frame(cfg[c], dat[c], b, nb, tk);
      p.nb = nb;
      wreg(OFS_DATA, dat[c] ^ 8'hFF);
      wreg(OFS_DATA, dat[c]);
      wait_idle();
      `CHK(p.seen, b)
      dg = p.gap - tk * DIV;
      `CHK(dg >= 0 && dg <= 2 * DIV + 2, 1'b1)
    end
    rx_case(8'h1B, 8'hA5, 12'h000, 8'h01, 8'hA5);
    rx_case(8'h1B, 8'hA5, 12'h200, 8'h05, 8'hA5);
    rx_case(8'h0B, 8'hA5, 12'h000, 8'h01, 8'hA5);
    rx_case(8'h0B, 8'hA5, 12'h200, 8'h05, 8'hA5);
    rx_case(8'h2B, 8'h3C, 12'h000, 8'h01, 8'h3C);
    rx_case(8'h3B, 8'h3C, 12'h200, 8'h05, 8'h3C);
    rx_case(8'h00, 8'hFF, 12'h000, 8'h01, 8'h1F);
    rx_case(8'h03, 8'h3C, 12'h000, 8'h01, 8'h3C);
    rx_case(8'h03, 8'h55, 12'h200, 8'h09, 8'h55);
    rx_case(8'h07, 8'h55, 12'h000, 8'h01, 8'h55);
    // fill faster than the line drains until the buffer refuses
    wreg(OFS_LCR, 8'h03);
    p.nb = 10;
    f0 = p.frames;
    acc = 0;
    for (int i = 0; i < 40; i++) wreg(OFS_DATA, 8'(i));
    `CHK(tx_fifo_ready, 1'b0)
    `CHK(acc >= 32 && acc <= 34, 1'b1)
    wait_idle();
    `CHK(p.frames - f0, acc)
    rchk(OFS_LSR, 8'hFF, 8'h60);
    wreg(OFS_LCR, 8'h43);
    wreg(OFS_DATA, 8'hFF);
    repeat (400) begin
      @(negedge mclk);
      if (serial_tx_pin !== 1'b0) bad++;
    end
    `CHK(bad, 0)
    wreg(OFS_LCR, 8'h03);
    wait_idle();
    `CHK(serial_tx_pin, 1'b1)
    results();
  end
endmodule

/* ulc_baud.sv */
/*
 Baud generator: one-cycle tick at sixteen times the baud rate.
 Assumes the divisor and its reload strobe come from mclk logic.
*/
`timescale 1ns/1ns
module ulc_baud (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // divisor
  input  wire logic [15:0] divisor,
  input  wire logic        reload,
  // 16x tick
  output logic             tick
);
  logic [15:0] cnt;
  logic [15:0] gap;
  logic        seen;
  // divisor zero stops the generator
  wire wrap = (cnt == 16'h0001) | (cnt == 16'h0000);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      cnt  <= (reload | wrap) ? divisor : 16'(cnt - 1'b1);
      tick <= ~reload & (cnt == 16'h0001);
    end
  end

  // helper: cycles between ticks
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gap  <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap  <= tick ? 16'h0001 : 16'(gap + 1'b1);
      seen <= reload ? 1'b0 : (seen | tick);
    end
  end

  property p_tick_period;
    @(posedge mclk) disable iff (!rstn)
      (tick && seen && !$past(reload)) |-> gap == divisor;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("baud tick spacing wrong");
endmodule

/* ulc_far_end.sv */
/*
 Far-end terminal model on the serial line: samples each character on tx
 at mid-bit, timestamps start edges and sends characters on rx.
 Assumes a fixed bit time of BIT mclk cycles set by the bench divisor.
*/
`timescale 1ns/1ns
module ulc_far_end #(
  parameter int BIT = 32
) (
  // clock
  input  wire logic mclk,
  // serial line
  input  wire logic tx,
  output logic      rx
);
  logic [11:0] seen;
  int          nb;
  int          gap;
  int          frames;
  int          cyc;
  int          last;

  initial begin
    rx = 1'b1;
    nb = 10;
    frames = 0;
    cyc = 0;
    last = 0;
  end

  always @(posedge mclk) cyc <= cyc + 1;

  // sampling stops mid first stop bit so the next start edge is never missed
  always begin
    @(negedge tx);
    gap = cyc - last;
    last = cyc;
    seen = '0;
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      seen[i] = tx;
      if (i < nb - 1) repeat (BIT) @(posedge mclk);
    end
    frames++;
  end

  // idle line rests high, as a terminal output does
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      rx = b[i];
      repeat (BIT - 1) @(negedge mclk);
    end
    @(negedge mclk);
    rx = 1'b1;
  endtask
endmodule

/* ulc_fifo.sv */
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module ulc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = cnt != D[AW:0];
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= AW'(wp + 1'b1);
      if (pop) rp <= AW'(rp + 1'b1);
      cnt <= (AW+1)'(cnt + push - pop);
    end
  end

  always_ff @(posedge mclk) begin
    if (push) mem[wp] <= in_data;
  end
endmodule

/* ulc_pkg.sv */
/*
 Constants shared by the serial port line-control block: register offsets,
 line-control field positions, reset values and bit timing.
 Assumes nothing of its surroundings.
*/
package ulc_pkg;
  // register offsets on the three address pins
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER  = 3'h1;
  localparam logic [2:0] OFS_IIR  = 3'h2;
  localparam logic [2:0] OFS_LCR  = 3'h3;
  localparam logic [2:0] OFS_MCR  = 3'h4;
  localparam logic [2:0] OFS_LSR  = 3'h5;
  localparam logic [2:0] OFS_MSR  = 3'h6;
  localparam logic [2:0] OFS_SCR  = 3'h7;
  // line_format_control fields
  localparam int LCR_WLS_LO = 0;
  localparam int LCR_WLS_HI = 1;
  localparam int LCR_STB    = 2;
  localparam int LCR_PEN    = 3;
  localparam int LCR_EPS    = 4;
  localparam int LCR_STP    = 5;
  localparam int LCR_BRK    = 6;
  localparam int LCR_DIVISOR_ACCESS_SELECT   = 7;
  // modem_line_control fields
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_LOOP = 4;
  // reset values
  localparam logic [7:0] RST_LCR = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_SCR = 8'h00;
  localparam logic [7:0] RST_IIR = 8'h01;
  // bit timing in 16x ticks
  localparam logic [5:0] TK_BIT    = 6'h0F;
  localparam logic [5:0] TK_STOP15 = 6'h17;
  localparam logic [5:0] TK_STOP2  = 6'h1F;
  localparam logic [3:0] TK_MID    = 4'h7;
  localparam logic [3:0] TK_END    = 4'hF;
  // transmit buffer
  localparam int TXF_WIDTH = 8;
  localparam int TXF_DEPTH = 32;
endpackage

/* ulc_top.sv */
/*
 Line control, register selection and character framing of a 16550-style
 serial port, with a 32-word transmit FIFO.
 Assumes bus strobes are one-cycle pulses on mclk; the serial input and
 modem inputs are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
//
// Overview of operation
// - divisor select low: offsets 0,1 reach receive, transmit and enable regs
// - divisor select high: offsets 0,1 reach divisor low and high bytes
// - line control at offset 3 whatever the divisor select
// - break clear: serial pin follows transmitter output
// - break set: serial pin held low until software clears it
// - parity on, not forced: even select picks parity sense
// - forced parity: bit sent and expected as inverse of even select
// - even select low: ones in data plus parity odd
// - even select high: ones in data plus parity even
// - parity off: no parity bit sent or checked
// - parity bit sits after last data bit, before stop
// - stop count low: one stop bit sent
// - stop count high, five bits: one and a half stop bits
// - stop count high, six to eight bits: two stop bits
// - stop count affects only transmitted format
// - word length bits give five to eight data bits both ways
// - baud tick at sixteen times rate, mclk divided by divisor
// - divisor write reloads counter; receiver idles, transmitter after char
module ulc_top
  import ulc_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // register port
  input  wire logic       cs,
  input  wire logic [2:0] addr,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata,
  output logic            tx_fifo_ready,
  // serial line
  input  wire logic       serial_rx_pin,
  output logic            serial_tx_pin,
  // modem lines, inputs {dcd, ri, dsr, cts}
  input  wire logic [3:0] modem_in,
  output logic            dtr,
  output logic            rts
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b011,
    ST_PAR = 3'b010, ST_STOP = 3'b110
  } ulc_state_e;

  function automatic logic [7:0] word_mask(input logic [7:0] d, input logic [1:0] wl);
    word_mask = d & (8'hFF >> (2'd3 - wl));
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lcr_v);
    logic [7:0] m;
    m = word_mask(d, lcr_v[LCR_WLS_HI:LCR_WLS_LO]);
    par_bit = lcr_v[LCR_STP] ? ~lcr_v[LCR_EPS]
                             : ((^m) ^ ~lcr_v[LCR_EPS]);
  endfunction

  logic [7:0] lcr, dll, dlm, scr, rbr;
  logic [3:0] ier;
  logic [4:0] mcr;
  logic       dr, oe, pe, fe, bi;
  logic       rx_s1, rx_s2;
  logic [3:0] md_s1, md_s2, md_prev, md_delta;
  logic [7:0] next_rdata;
  logic       tick;

  // register decode
  wire        divisor_access_select    = lcr[LCR_DIVISOR_ACCESS_SELECT];
  wire        wr_go   = cs & wr;
  wire        rd_go   = cs & rd;
  wire        sel_dll = (addr == OFS_DATA) & divisor_access_select;
  wire        sel_dlm = (addr == OFS_IER) & divisor_access_select;
  wire        sel_rbr = (addr == OFS_DATA) & ~divisor_access_select;
  wire        sel_ier = (addr == OFS_IER) & ~divisor_access_select;
  wire        wr_div  = wr_go & (sel_dll | sel_dlm);
  wire        wr_thr  = wr_go & sel_rbr;
  wire        rd_rbr  = rd_go & sel_rbr;
  wire        rd_lsr  = rd_go & (addr == OFS_LSR);
  wire        rd_msr  = rd_go & (addr == OFS_MSR);
  wire [1:0]  wl      = lcr[LCR_WLS_HI:LCR_WLS_LO];
  // index of the last data bit: four plus the length code
  wire [2:0]  wl_m1   = {1'b1, wl};
  wire [3:0]  md_edge = {md_s2[3] ^ md_prev[3], md_prev[2] & ~md_s2[2],
                         md_s2[1:0] ^ md_prev[1:0]};

  // transmit side
  ulc_state_e tx_st;
  logic [5:0] tx_tk;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh, tx_word;
  logic       tx_par, tx_hold;
  logic       f_valid;
  logic [7:0] f_data;
  wire        tx_take = (tx_st == ST_IDLE) & f_valid & ~tx_hold;
  wire [5:0]  stop_last = ~lcr[LCR_STB] ? TK_BIT :
                          (wl == 2'b00) ? TK_STOP15 : TK_STOP2;
  wire [5:0]  tx_last = (tx_st == ST_STOP) ? stop_last : TK_BIT;
  wire        tx_end  = tick & (tx_tk == tx_last);
  wire        tx_line = (tx_st == ST_START) ? 1'b0 : (tx_st == ST_DATA) ? tx_sh[0] :
                        (tx_st == ST_PAR) ? tx_par : 1'b1;
  wire [7:0]  lsr = {1'b0, ~f_valid & (tx_st == ST_IDLE), ~f_valid, bi, fe, pe, oe, dr};

  // receive side
  ulc_state_e rx_st;
  logic [3:0] rx_tk;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic       rx_perr, rx_ones;
  wire        rx_in    = mcr[MCR_LOOP] ? tx_line : rx_s2;
  wire        rx_samp  = tick & (rx_tk == ((rx_st == ST_START) ? TK_MID : TK_END));
  wire [7:0]  rx_word  = rx_sh >> (3'd7 - wl_m1);
  wire        rx_done  = rx_samp & (rx_st == ST_STOP) & ~wr_div;

  logic f_in_ready;

  assign tx_fifo_ready = f_in_ready;
  assign dtr = mcr[MCR_DTR];
  assign rts = mcr[MCR_RTS];

  ulc_fifo #(.W(TXF_WIDTH), .D(TXF_DEPTH)) u_txf (
    .mclk     (mclk),
    .rstn     (rstn),
    .in_valid (wr_thr),
    .in_ready (f_in_ready),
    .in_data  (wdata),
    .out_valid(f_valid),
    .out_ready(tx_take),
    .out_data (f_data)
  );

  ulc_baud u_baud (
    .mclk   (mclk),
    .rstn   (rstn),
    .divisor({dlm, dll}),
    .reload (wr_div),
    .tick   (tick)
  );

  // read mux; offsets 2..7 ignore the divisor select
  always_comb begin
    unique case (addr)
      OFS_DATA: next_rdata = divisor_access_select ? dll : rbr;
      OFS_IER:  next_rdata = divisor_access_select ? dlm : {4'h0, ier};
      OFS_IIR:  next_rdata = RST_IIR;
      OFS_LCR:  next_rdata = lcr;
      OFS_MCR:  next_rdata = {3'h0, mcr};
      OFS_LSR:  next_rdata = lsr;
      OFS_MSR:  next_rdata = {md_s2, md_delta};
      OFS_SCR:  next_rdata = scr;
    endcase
  end

  // register writes and flags; a setting event wins over a read-clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {lcr, dll, dlm, scr} <= {RST_LCR, RST_DIV, RST_DIV, RST_SCR};
      ier   <= 4'h0;
      mcr   <= 5'h00;
      rdata <= 8'h00;
    end else begin
      if (rd_go) rdata <= next_rdata;
      if (wr_go & sel_dll) dll <= wdata;
      if (wr_go & sel_dlm) dlm <= wdata;
      if (wr_go & sel_ier) ier <= wdata[3:0];
      if (wr_go & (addr == OFS_LCR)) lcr <= wdata;
      if (wr_go & (addr == OFS_MCR)) mcr <= wdata[4:0];
      if (wr_go & (addr == OFS_SCR)) scr <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {rx_s1, rx_s2} <= 2'b11;
      {md_s1, md_s2, md_prev, md_delta} <= 16'h0000;
      {dr, oe, pe, fe, bi} <= 5'h00;
      rbr <= 8'h00;
    end else begin
      rx_s1    <= serial_rx_pin;
      rx_s2    <= rx_s1;
      md_s1    <= modem_in;
      md_s2    <= md_s1;
      md_prev  <= md_s2;
      md_delta <= md_edge | (rd_msr ? 4'h0 : md_delta);
      dr <= rx_done | (dr & ~rd_rbr);
      oe <= (rx_done & dr & ~rd_rbr) | (oe & ~rd_lsr);
      pe <= (rx_done & rx_perr) | (pe & ~rd_lsr);
      fe <= (rx_done & ~rx_in) | (fe & ~rd_lsr);
      bi <= (rx_done & ~rx_in & ~rx_ones) | (bi & ~rd_lsr);
      if (rx_done) rbr <= word_mask(rx_word, wl);
    end
  end

  // transmitter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_st   <= ST_IDLE;
      {tx_tk, tx_bit, tx_sh, tx_word, tx_par, tx_hold} <= 27'h0;
      serial_tx_pin <= 1'b1;
    end else begin
      serial_tx_pin <= lcr[LCR_BRK] ? 1'b0 : tx_line;
      // finish the current char, then one idle cycle
      tx_hold <= wr_div | (tx_hold & (tx_st != ST_IDLE));
      if (tx_take) begin
        tx_st   <= ST_START;
        tx_tk   <= 6'h00;
        tx_sh   <= f_data;
        tx_word <= word_mask(f_data, wl);
        tx_par  <= par_bit(f_data, lcr);
      end else if (tx_end) begin
        tx_tk <= 6'h00;
        unique case (tx_st)
          ST_START: begin
            tx_st  <= ST_DATA;
            tx_bit <= 3'h0;
          end
          ST_DATA: begin
            tx_sh  <= {1'b0, tx_sh[7:1]};
            tx_bit <= 3'(tx_bit + 1'b1);
            if (tx_bit == wl_m1) tx_st <= lcr[LCR_PEN] ? ST_PAR : ST_STOP;
          end
          ST_PAR:  tx_st <= ST_STOP;
          ST_STOP: tx_st <= ST_IDLE;
          ST_IDLE: tx_st <= ST_IDLE;
        endcase
      end else if (tick) begin
        tx_tk <= 6'(tx_tk + 1'b1);
      end
    end
  end

  // receiver; samples mid-bit, one stop bit only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_st <= ST_IDLE;
      {rx_tk, rx_bit, rx_sh, rx_perr, rx_ones} <= 17'h0;
    end else if (wr_div) begin
      rx_st <= ST_IDLE;
    end else if (rx_st == ST_IDLE) begin
      rx_tk   <= 4'h0;
      rx_ones <= 1'b0;
      rx_perr <= 1'b0;
      if (!rx_in) rx_st <= ST_START;
    end else if (rx_samp) begin
      rx_tk <= 4'h0;
      rx_ones <= rx_ones | rx_in;
      unique case (rx_st)
        ST_START: begin
          rx_st  <= rx_in ? ST_IDLE : ST_DATA;
          rx_bit <= 3'h0;
        end
        ST_DATA: begin
          rx_sh  <= {rx_in, rx_sh[7:1]};
          rx_bit <= 3'(rx_bit + 1'b1);
          if (rx_bit == wl_m1) rx_st <= lcr[LCR_PEN] ? ST_PAR : ST_STOP;
        end
        ST_PAR: begin
          rx_perr <= rx_in ^ par_bit(rx_word, lcr);
          rx_st   <= ST_STOP;
        end
        default: rx_st <= ST_IDLE;
      endcase
    end else if (tick) begin
      rx_tk <= 4'(rx_tk + 1'b1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_rbr_read;
    rd_rbr |=> rdata == $past(rbr);
  endproperty
  a_rbr_read: assert property (p_rbr_read) else $error("receive data not returned");
  property p_div_read;
    (rd_go && sel_dll) |=> rdata == $past(dll);
  endproperty
  a_div_read: assert property (p_div_read) else $error("divisor low not returned");
  property p_lcr_read;
    (rd_go && addr == OFS_LCR) |=> rdata == $past(lcr);
  endproperty
  a_lcr_read: assert property (p_lcr_read) else $error("line control not returned");
  property p_follow;
    !lcr[LCR_BRK] |=> serial_tx_pin == $past(tx_line);
  endproperty
  a_follow: assert property (p_follow) else $error("serial pin not following");
  property p_break;
    lcr[LCR_BRK] [*2] |-> !serial_tx_pin;
  endproperty
  a_break: assert property (p_break) else $error("break not held low");
  property p_par_sense;
    (tx_st == ST_PAR && !lcr[LCR_STP]) |-> ((^tx_word) ^ tx_par) == !lcr[LCR_EPS];
  endproperty
  a_par_sense: assert property (p_par_sense) else $error("parity sense wrong");
  property p_stick;
    (tx_st == ST_PAR && lcr[LCR_STP]) |-> tx_par == !lcr[LCR_EPS];
  endproperty
  a_stick: assert property (p_stick) else $error("forced parity level wrong");
  property p_no_par;
    (tx_st == ST_DATA && !lcr[LCR_PEN]) |=> tx_st != ST_PAR;
  endproperty
  a_no_par: assert property (p_no_par) else $error("parity sent while off");
  property p_stop_len;
    (tx_st == ST_STOP && lcr[LCR_STB]) |-> tx_last == ((wl == 2'b00) ? 6'd23 : 6'd31);
  endproperty
  a_stop_len: assert property (p_stop_len) else $error("stop length wrong");
  property p_fe;
    (rx_done && !rx_in) |=> fe;
  endproperty
  a_fe: assert property (p_fe) else $error("framing error missed");
  property p_div_idle;
    wr_div |=> rx_st == ST_IDLE;
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("receiver not idled");

  c_break:  cover property (lcr[LCR_BRK] && tx_st == ST_DATA);
  c_fe:     cover property (rx_done && !rx_in);
  c_parity: cover property (tx_st == ST_PAR);
  c_full:   cover property (!f_in_ready);
endmodule
